// File: board_model.sv
// Board-side model: resolves every port pin from device drive, board drivers and pull-ups
`timescale 1ns/100ps
`default_nettype none
module board_model (
   // Clock
   input  wire logic                                          mclk,
   // Device side
   input  wire port_pin_function_mux_pkg::line_drive_t [12:0] pinDrive,
   // Board drivers, boardOeN low means the board drives boardVal
   input  wire logic [12:0]                                   boardOeN,
   input  wire logic [12:0]                                   boardVal,
   // Resolved pin levels
   output logic      [12:0]                                   pinIn
);
   logic floatPat = 1'b0;

   // An undriven pin without pull-up never keeps the last value it saw
   always @(posedge mclk) begin
      floatPat <= ~floatPat;
   end

   always_comb begin
      for (int i = 0; i < 13; i++) begin
         if (!pinDrive[i].oeN) pinIn[i] = pinDrive[i].out;
         else if (!boardOeN[i]) pinIn[i] = boardVal[i];
         else if (pinDrive[i].pullEn) pinIn[i] = 1'b1;
         else pinIn[i] = floatPat ^ i[0];
      end
   end
endmodule : board_model
`default_nettype wire

// File: port_pin_function_mux.sv
// Pin function multiplexer: three ports, peripheral alternates, NMI, reset and test pins
`timescale 1ns/100ps
`default_nettype none

// Operation
// - First port has four lines: input, pulled input, interrupt input, OD/PP output, analog.
// - Second port low four lines: same modes as first port except analog.
// - Timer output drives the timer output line when its control bit is set.
// - Third port has three lines with all modes including analog.
// - Third port lines carry SPI data in, data out and clock as alternate.
// - Every falling edge on the asynchronous NMI pin raises a non-maskable interrupt.
// - A low reset pin restarts the whole chip.
// - Programming mode is entered only when test pin is high during reset.
module port_pin_function_mux (
   // Clock, reset, enable
   input  wire logic                                       mclk,
   input  wire logic                                       sys_rst,
   input  wire logic                                       clkEn,
   // Avalon-MM slave
   input  wire logic [5:0]                                 avsAddress,
   input  wire logic                                       avsRead,
   input  wire logic                                       avsWrite,
   input  wire logic [31:0]                                avsWritedata,
   input  wire logic [3:0]                                 avsByteenable,
   output logic      [31:0]                                avsReaddata,
   output logic                                            avsWaitrequest,
   // Port lines
   input  wire logic [port_pin_function_mux_pkg::NUM_LINES-1:0] pinIn,
   output port_pin_function_mux_pkg::line_drive_t [port_pin_function_mux_pkg::NUM_LINES-1:0] pinDrive,
   // Auto-reload timer
   input  wire logic                                       reloadTimerOutput,
   output logic                                            reloadTimerInput,
   // SPI
   input  wire logic                                       spiDataOut,
   input  wire logic                                       spiClkOut,
   input  wire logic                                       spiClkOeN,
   output logic                                            spiDataIn,
   output logic                                            spiClkIn,
   // Dedicated pins
   input  wire logic                                       nmiPinIn,
   input  wire logic                                       resetPinN,
   input  wire logic                                       testPinHigh,
   output logic                                            nmiPulse,
   output logic                                            chipReset,
   output logic                                            progMode,
   // Interrupt
   output logic                                            irq
);

   localparam int NL = port_pin_function_mux_pkg::NUM_LINES;
   localparam int NP = port_pin_function_mux_pkg::NUM_PORTS;
   localparam int IW = port_pin_function_mux_pkg::IRQ_W;

   port_pin_function_mux_pkg::port_regs_t    portRegs_reg [NP];
   logic [port_pin_function_mux_pkg::CTRL_W-1:0] ctrl_reg;
   logic [IW-1:0]                             irqStat_reg;
   logic [IW-1:0]                             irqMask_reg;
   port_pin_function_mux_pkg::bus_state_t     busState_reg;
   logic [NL-1:0]                             prevPin_reg;
   logic [NL-1:0]                             lineFall;
   logic [7:0]                                pinView [NP];
   logic [31:0]                               readdata_next;
   logic [IW-1:0]                             irqStat_next;
   logic                                      nmiSync1_reg;
   logic                                      nmiSync2_reg;
   logic                                      nmiSync3_reg;
   logic                                      nmiFall;
   logic                                      rstSync1_reg;
   logic                                      writeCommit;
   logic                                      timerOutEn;
   logic                                      spiEn;

   assign timerOutEn  = ctrl_reg[port_pin_function_mux_pkg::CTRL_TIMER_OUT_BIT];
   assign spiEn       = ctrl_reg[port_pin_function_mux_pkg::CTRL_SPI_EN_BIT];
   // Writes land at the edge where waitrequest is seen low
   assign writeCommit = (busState_reg == port_pin_function_mux_pkg::BUS_ACK) && avsWrite
                        && avsByteenable[0];

   // ---------------- Bus slave ----------------
   always_comb begin
      readdata_next = 32'h0000_0000;
      for (int p = 0; p < NP; p++) begin
         if (avsAddress == port_pin_function_mux_pkg::OFS_DATA[p]) begin
            readdata_next = {24'h00_0000, pinView[p]};
         end
         if (avsAddress == port_pin_function_mux_pkg::OFS_DIR[p]) begin
            readdata_next = {24'h00_0000, portRegs_reg[p].dir};
         end
         if (avsAddress == port_pin_function_mux_pkg::OFS_OPT[p]) begin
            readdata_next = {24'h00_0000, portRegs_reg[p].opt};
         end
      end
      if (avsAddress == port_pin_function_mux_pkg::OFS_CTRL) begin
         readdata_next = {30'h0000_0000, ctrl_reg};
      end
      if (avsAddress == port_pin_function_mux_pkg::OFS_IRQ_STAT) begin
         readdata_next = {18'h0_0000, irqStat_reg};
      end
      if (avsAddress == port_pin_function_mux_pkg::OFS_IRQ_MASK) begin
         readdata_next = {18'h0_0000, irqMask_reg};
      end
   end

   // One wait cycle on every access; unmapped reads return zero
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         busState_reg   <= port_pin_function_mux_pkg::BUS_IDLE;
         avsWaitrequest <= 1'b1;
         avsReaddata    <= 32'h0000_0000;
      end else if (clkEn) begin
         case (busState_reg)
            port_pin_function_mux_pkg::BUS_IDLE: begin
               if (avsRead || avsWrite) begin
                  busState_reg   <= port_pin_function_mux_pkg::BUS_ACK;
                  avsWaitrequest <= 1'b0;
                  avsReaddata    <= readdata_next;
               end
            end
            port_pin_function_mux_pkg::BUS_ACK: begin
               busState_reg   <= port_pin_function_mux_pkg::BUS_IDLE;
               avsWaitrequest <= 1'b1;
            end
            default: begin
               busState_reg   <= port_pin_function_mux_pkg::BUS_IDLE;
               avsWaitrequest <= 1'b1;
            end
         endcase
      end
   end

   // Port configuration registers; unimplemented bits are kept but have no pin
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         for (int p = 0; p < NP; p++) begin
            portRegs_reg[p] <= '{data: port_pin_function_mux_pkg::PORT_REG_RESET,
                                 dir:  port_pin_function_mux_pkg::PORT_REG_RESET,
                                 opt:  port_pin_function_mux_pkg::PORT_REG_RESET};
         end
      end else if (clkEn && writeCommit) begin
         for (int p = 0; p < NP; p++) begin
            if (avsAddress == port_pin_function_mux_pkg::OFS_DATA[p]) begin
               portRegs_reg[p].data <= avsWritedata[7:0];
            end
            if (avsAddress == port_pin_function_mux_pkg::OFS_DIR[p]) begin
               portRegs_reg[p].dir <= avsWritedata[7:0];
            end
            if (avsAddress == port_pin_function_mux_pkg::OFS_OPT[p]) begin
               portRegs_reg[p].opt <= avsWritedata[7:0];
            end
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         ctrl_reg    <= port_pin_function_mux_pkg::CTRL_RESET;
         irqMask_reg <= port_pin_function_mux_pkg::IRQ_RESET;
      end else if (clkEn && writeCommit) begin
         if (avsAddress == port_pin_function_mux_pkg::OFS_CTRL) begin
            ctrl_reg <= avsWritedata[port_pin_function_mux_pkg::CTRL_W-1:0];
         end
         if (avsAddress == port_pin_function_mux_pkg::OFS_IRQ_MASK) begin
            irqMask_reg <= avsWritedata[IW-1:0];
         end
      end
   end

   // Input lines read the pin, output lines read back the latch
   always_comb begin
      for (int p = 0; p < NP; p++) begin
         pinView[p] = 8'h00;
      end
      for (int i = 0; i < NL; i++) begin
         pinView[port_pin_function_mux_pkg::LINE_PORT[i]][port_pin_function_mux_pkg::LINE_BIT[i]] =
            portRegs_reg[port_pin_function_mux_pkg::LINE_PORT[i]].dir[port_pin_function_mux_pkg::LINE_BIT[i]]
            ? portRegs_reg[port_pin_function_mux_pkg::LINE_PORT[i]].data[port_pin_function_mux_pkg::LINE_BIT[i]]
            : pinIn[i];
      end
   end

   // ---------------- Per-line mode decode ----------------
   // dir=0: data/opt 00 pulled input, 10 plain input, 01 interrupt input, 11 analog
   // dir=1: opt 0 open drain, opt 1 push-pull
   generate
      for (genvar i = 0; i < NL; i++) begin : g_line
         localparam int P = port_pin_function_mux_pkg::LINE_PORT[i];
         localparam int B = port_pin_function_mux_pkg::LINE_BIT[i];
         logic                                   dBit;
         logic                                   dirBit;
         logic                                   optBit;
         port_pin_function_mux_pkg::line_drive_t drive_next;

         assign dBit   = portRegs_reg[P].data[B];
         assign dirBit = portRegs_reg[P].dir[B];
         assign optBit = portRegs_reg[P].opt[B];
         assign lineFall[i] = !dirBit && optBit && !dBit && prevPin_reg[i] && !pinIn[i];

         always_comb begin
            drive_next.anaSel = !dirBit && optBit && dBit && port_pin_function_mux_pkg::ANALOG_MASK[i];
            drive_next.pullEn = !dirBit && !dBit;
            drive_next.out    = dBit;
            drive_next.oeN    = !(dirBit && (optBit || !dBit));
            if (dirBit) begin
               drive_next.out = optBit ? dBit : 1'b0;
            end
            if (i == port_pin_function_mux_pkg::LN_TIMER_OUT && timerOutEn) begin
               drive_next = '{out: reloadTimerOutput, oeN: 1'b0, pullEn: 1'b0, anaSel: 1'b0};
            end
            if (spiEn) begin
               if (i == port_pin_function_mux_pkg::LN_SPI_DIN) begin
                  drive_next.oeN    = 1'b1;
                  drive_next.anaSel = 1'b0;
               end
               if (i == port_pin_function_mux_pkg::LN_SPI_DOUT) begin
                  drive_next = '{out: spiDataOut, oeN: 1'b0, pullEn: 1'b0, anaSel: 1'b0};
               end
               if (i == port_pin_function_mux_pkg::LN_SPI_CLK) begin
                  drive_next = '{out: spiClkOut, oeN: spiClkOeN, pullEn: 1'b0, anaSel: 1'b0};
               end
            end
         end

         always_ff @(posedge mclk) begin
            if (sys_rst) begin
               pinDrive[i]    <= port_pin_function_mux_pkg::DRIVE_RESET;
               prevPin_reg[i] <= 1'b1;
            end else if (clkEn) begin
               pinDrive[i]    <= drive_next;
               prevPin_reg[i] <= pinIn[i];
            end
         end
      end
   endgenerate

   // Peripheral sampling paths, always live so the peripheral owns the enable
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         reloadTimerInput <= 1'b0;
         spiDataIn        <= 1'b0;
         spiClkIn         <= 1'b0;
      end else if (clkEn) begin
         reloadTimerInput <= pinIn[port_pin_function_mux_pkg::LN_TIMER_IN];
         spiDataIn        <= pinIn[port_pin_function_mux_pkg::LN_SPI_DIN];
         spiClkIn         <= pinIn[port_pin_function_mux_pkg::LN_SPI_CLK];
      end
   end

   // ---------------- NMI ----------------
   // Pin is asynchronous; two stages before any edge logic looks at it
   assign nmiFall = nmiSync3_reg && !nmiSync2_reg;

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         nmiSync1_reg <= 1'b1;
         nmiSync2_reg <= 1'b1;
         nmiSync3_reg <= 1'b1;
         nmiPulse     <= 1'b0;
      end else if (clkEn) begin
         nmiSync1_reg <= nmiPinIn;
         nmiSync2_reg <= nmiSync1_reg;
         nmiSync3_reg <= nmiSync2_reg;
         nmiPulse     <= nmiFall;
      end
   end

   // ---------------- Interrupt status ----------------
   // A new event wins over a simultaneous write-one-to-clear
   always_comb begin
      irqStat_next = irqStat_reg;
      if (writeCommit && avsAddress == port_pin_function_mux_pkg::OFS_IRQ_STAT) begin
         irqStat_next = irqStat_reg & ~avsWritedata[IW-1:0];
      end
      irqStat_next = irqStat_next | {nmiFall, lineFall};
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         irqStat_reg <= port_pin_function_mux_pkg::IRQ_RESET;
         irq         <= 1'b0;
      end else if (clkEn) begin
         irqStat_reg <= irqStat_next;
         irq         <= |(irqStat_reg & irqMask_reg);
      end
   end

   // ---------------- Reset and test pins ----------------
   // Test level is taken in the last cycle of the reset phase, so a late rise still counts
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         rstSync1_reg <= 1'b1;
         chipReset    <= 1'b0;
         progMode     <= 1'b0;
      end else if (clkEn) begin
         rstSync1_reg <= resetPinN;
         chipReset    <= !rstSync1_reg;
         if (chipReset && rstSync1_reg) begin
            progMode <= testPinHigh;
         end
      end
   end

   // ---------------- Assertions ----------------
   a_first_analog: assert property (@(posedge mclk) disable iff (sys_rst)
      ($past(clkEn) && !$past(sys_rst) && $past(!portRegs_reg[0].dir[0] && portRegs_reg[0].opt[0]
       && portRegs_reg[0].data[0])) |-> (pinDrive[0].anaSel && pinDrive[0].oeN))
      else $error("first port line 0 not analog");

   a_second_no_analog: assert property (@(posedge mclk) disable iff (sys_rst)
      !(pinDrive[4].anaSel || pinDrive[5].anaSel || pinDrive[6].anaSel || pinDrive[7].anaSel
        || pinDrive[8].anaSel || pinDrive[9].anaSel))
      else $error("second port line in analog mode");

   a_timer_out_route: assert property (@(posedge mclk) disable iff (sys_rst)
      ($past(clkEn) && !$past(sys_rst) && $past(timerOutEn)) |->
      (!pinDrive[port_pin_function_mux_pkg::LN_TIMER_OUT].oeN
       && pinDrive[port_pin_function_mux_pkg::LN_TIMER_OUT].out == $past(reloadTimerOutput)))
      else $error("timer output not on its line");

   a_third_analog: assert property (@(posedge mclk) disable iff (sys_rst)
      ($past(clkEn) && !$past(sys_rst) && !$past(spiEn) && $past(!portRegs_reg[2].dir[2]
       && portRegs_reg[2].opt[2] && portRegs_reg[2].data[2])) |-> pinDrive[10].anaSel)
      else $error("third port line not analog");

   a_spi_dout_route: assert property (@(posedge mclk) disable iff (sys_rst)
      ($past(clkEn) && !$past(sys_rst) && $past(spiEn)) |->
      (!pinDrive[port_pin_function_mux_pkg::LN_SPI_DOUT].oeN
       && pinDrive[port_pin_function_mux_pkg::LN_SPI_DOUT].out == $past(spiDataOut)))
      else $error("SPI data out not on its line");

   a_nmi_edge: assert property (@(posedge mclk) disable iff (sys_rst)
      (clkEn && nmiSync3_reg && !nmiSync2_reg) |=>
      (nmiPulse && irqStat_reg[port_pin_function_mux_pkg::IRQ_NMI_BIT]))
      else $error("NMI edge lost");

   a_reset_pin: assert property (@(posedge mclk) disable iff (sys_rst)
      (clkEn && !resetPinN) [*3] |-> chipReset)
      else $error("reset pin did not reset chip");

   a_prog_entry: assert property (@(posedge mclk) disable iff (sys_rst)
      $changed(progMode) |-> ($past(chipReset) && !chipReset))
      else $error("programming mode changed outside reset release");

   a_spi_din_input: assert property (@(posedge mclk) disable iff (sys_rst)
      ($past(clkEn) && !$past(sys_rst) && $past(spiEn)) |->
      (pinDrive[port_pin_function_mux_pkg::LN_SPI_DIN].oeN && spiDataIn == $past(pinIn[10])))
      else $error("SPI data in line driven");

endmodule : port_pin_function_mux
`default_nettype wire

// File: port_pin_function_mux_pkg.sv
// Constants, register map and carrier types for the pin function multiplexer
`default_nettype none
package port_pin_function_mux_pkg;

   // Line indices: 0-3 first port, 4-7 second port low, 8 timer in, 9 timer out, 10-12 third port
   localparam int NUM_LINES    = 13;
   localparam int NUM_PORTS    = 3;
   localparam int LN_TIMER_IN  = 8;
   localparam int LN_TIMER_OUT = 9;
   localparam int LN_SPI_DIN   = 10;
   localparam int LN_SPI_DOUT  = 11;
   localparam int LN_SPI_CLK   = 12;

   // Port and bit position of each line inside the port registers
   localparam int LINE_PORT [NUM_LINES] = '{0, 0, 0, 0, 1, 1, 1, 1, 1, 1, 2, 2, 2};
   localparam int LINE_BIT  [NUM_LINES] = '{0, 1, 2, 3, 0, 1, 2, 3, 6, 7, 2, 3, 4};

   // Lines that can feed the converter
   localparam logic [NUM_LINES-1:0] ANALOG_MASK = 13'h1C0F;

   // Register byte offsets
   localparam logic [5:0] OFS_DATA [NUM_PORTS] = '{6'h00, 6'h04, 6'h08};
   localparam logic [5:0] OFS_DIR  [NUM_PORTS] = '{6'h0C, 6'h10, 6'h14};
   localparam logic [5:0] OFS_OPT  [NUM_PORTS] = '{6'h18, 6'h1C, 6'h20};
   localparam logic [5:0] OFS_CTRL      = 6'h24;
   localparam logic [5:0] OFS_IRQ_STAT  = 6'h28;
   localparam logic [5:0] OFS_IRQ_MASK  = 6'h2C;

   // Control register fields
   localparam int CTRL_TIMER_OUT_BIT = 0;
   localparam int CTRL_SPI_EN_BIT    = 1;
   localparam int CTRL_W             = 2;

   // Interrupt status layout: bits 12..0 line events, bit 13 external NMI
   localparam int IRQ_NMI_BIT = 13;
   localparam int IRQ_W       = 14;

   // Reset values
   localparam logic [7:0]        PORT_REG_RESET = 8'h00;
   localparam logic [CTRL_W-1:0] CTRL_RESET     = 2'h0;
   localparam logic [IRQ_W-1:0]  IRQ_RESET      = 14'h0000;

   typedef struct packed {
      logic out;
      logic oeN;
      logic pullEn;
      logic anaSel;
   } line_drive_t;

   typedef struct packed {
      logic [7:0] data;
      logic [7:0] dir;
      logic [7:0] opt;
   } port_regs_t;

   // Input with pull-up, released pin
   localparam line_drive_t DRIVE_RESET = '{out: 1'b0, oeN: 1'b1, pullEn: 1'b1, anaSel: 1'b0};

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_ACK  = 2'b01
   } bus_state_t;

endpackage : port_pin_function_mux_pkg
`default_nettype wire

// File: testbench.sv
// Self-checking testbench for the pin function multiplexer
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic        mclk = 1'b0;
   logic        sys_rst = 1'b1;
   logic [5:0]  avsAddress = 6'h00;
   logic        avsRead = 1'b0;
   logic        avsWrite = 1'b0;
   logic [31:0] avsWritedata = 32'h0000_0000;
   logic [3:0]  byteEn = 4'hF;
   logic [31:0] avsReaddata;
   logic        avsWaitrequest;
   logic [12:0] pinIn;
   logic [12:0] boardOeN = 13'h1FFF;
   logic [12:0] boardVal = 13'h0000;
   port_pin_function_mux_pkg::line_drive_t [12:0] pinDrive;
   logic        timerOut = 1'b0, spiDout = 1'b0, spiClk = 1'b0, spiClkOeN = 1'b1;
   logic        nmiPin = 1'b1, resetPinN = 1'b1, testPin = 1'b0;
   logic        timerIn, spiDin, spiClkIn, nmiPulse, chipReset, progMode, irq;
   int          errors = 0;
   int          comparisons = 0;
   int          n;

   always #5 mclk = ~mclk;

   port_pin_function_mux i_dut (
      .mclk(mclk), .sys_rst(sys_rst), .clkEn(1'b1),
      .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
      .avsWritedata(avsWritedata), .avsByteenable(byteEn), .avsReaddata(avsReaddata),
      .avsWaitrequest(avsWaitrequest), .pinIn(pinIn), .pinDrive(pinDrive),
      .reloadTimerOutput(timerOut), .reloadTimerInput(timerIn), .spiDataOut(spiDout),
      .spiClkOut(spiClk), .spiClkOeN(spiClkOeN), .spiDataIn(spiDin), .spiClkIn(spiClkIn),
      .nmiPinIn(nmiPin), .resetPinN(resetPinN), .testPinHigh(testPin), .nmiPulse(nmiPulse),
      .chipReset(chipReset), .progMode(progMode), .irq(irq));

   board_model i_board (.mclk(mclk), .pinDrive(pinDrive), .boardOeN(boardOeN),
                        .boardVal(boardVal), .pinIn(pinIn));

   task automatic test_done();
      if (errors == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : test_done

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
         errors++;
      end
   endtask : chk

   // Values sampled right after the edge are the ones the edge itself saw
   task automatic waitAck();
      int k;
      k = 0;
      do begin
         @(posedge mclk);
         k++;
      end while (avsWaitrequest !== 1'b0 && k < 100);
      if (avsWaitrequest !== 1'b0) chk("waitrequest", 32'h0000_0000, 32'h0000_0001);
      avsRead <= 1'b0;
      avsWrite <= 1'b0;
   endtask : waitAck

   task automatic busWrite(input logic [5:0] a, input logic [31:0] d);
      @(posedge mclk);
      avsAddress <= a;
      avsWritedata <= d;
      avsWrite <= 1'b1;
      waitAck();
   endtask : busWrite

   task automatic readChk(input string name, input logic [5:0] a, input logic [31:0] exp);
      @(posedge mclk);
      avsAddress <= a;
      avsRead <= 1'b1;
      waitAck();
      chk(name, exp, avsReaddata);
   endtask : readChk

   task automatic settle();
      repeat (4) @(posedge mclk);
   endtask : settle

   task automatic lineChk(input int i, input logic [1:0] exp);
      chk($sformatf("line%0d", i), {30'h0000_0000, exp}, {30'h0000_0000, pinDrive[i].out,
          pinDrive[i].oeN});
   endtask : lineChk

   task automatic countPulse(output int c);
      c = 0;
      repeat (10) begin
         @(posedge mclk);
         if (nmiPulse === 1'b1) c++;
      end
   endtask : countPulse

   initial begin
      repeat (10) @(posedge mclk);
      sys_rst <= 1'b0;
      @(posedge mclk);
      for (int i = 0; i < 13; i++) chk("resetDrive", {28'h000_0000,
          port_pin_function_mux_pkg::DRIVE_RESET}, {28'h000_0000, pinDrive[i]});
      for (int p = 0; p < 3; p++) begin
         readChk("dir", port_pin_function_mux_pkg::OFS_DIR[p], 32'h0000_0000);
         readChk("opt", port_pin_function_mux_pkg::OFS_OPT[p], 32'h0000_0000);
      end
      readChk("ctrl", port_pin_function_mux_pkg::OFS_CTRL, 32'h0000_0000);
      readChk("stat", port_pin_function_mux_pkg::OFS_IRQ_STAT, 32'h0000_0000);
      readChk("unmapped", 6'h3C, 32'h0000_0000);
      // Interrupt input on line 0: raise, clear, mask
      byteEn <= 4'h0;
      busWrite(port_pin_function_mux_pkg::OFS_IRQ_MASK, 32'h0000_0001);
      byteEn <= 4'hF;
      readChk("maskNoBe", port_pin_function_mux_pkg::OFS_IRQ_MASK, 32'h0000_0000);
      busWrite(port_pin_function_mux_pkg::OFS_OPT[0], 32'h0000_0001);
      busWrite(port_pin_function_mux_pkg::OFS_IRQ_MASK, 32'h0000_0001);
      boardOeN[0] <= 1'b0;
      settle();
      readChk("statLine0", port_pin_function_mux_pkg::OFS_IRQ_STAT, 32'h0000_0001);
      chk("irqSet", 32'h0000_0001, {31'h0000_0000, irq});
      boardOeN[0] <= 1'b1;
      busWrite(port_pin_function_mux_pkg::OFS_IRQ_STAT, 32'h0000_0001);
      settle();
      chk("irqClear", 32'h0000_0000, {31'h0000_0000, irq});
      busWrite(port_pin_function_mux_pkg::OFS_IRQ_MASK, 32'h0000_0000);
      boardOeN[0] <= 1'b0;
      settle();
      chk("irqMasked", 32'h0000_0000, {31'h0000_0000, irq});
      boardOeN[0] <= 1'b1;
      busWrite(port_pin_function_mux_pkg::OFS_IRQ_STAT, 32'h0000_0001);
      // Analog mode: data before option so no line passes through interrupt mode
      for (int p = 0; p < 3; p++) begin
         busWrite(port_pin_function_mux_pkg::OFS_DATA[p], 32'h0000_00FF);
         busWrite(port_pin_function_mux_pkg::OFS_OPT[p], 32'h0000_00FF);
      end
      settle();
      for (int i = 0; i < 13; i++) chk($sformatf("ana%0d", i), {31'h0000_0000,
          port_pin_function_mux_pkg::ANALOG_MASK[i]}, {31'h0000_0000, pinDrive[i].anaSel});
      // Outputs: direction first so no line passes through interrupt mode
      busWrite(port_pin_function_mux_pkg::OFS_DIR[0], 32'h0000_000F);
      busWrite(port_pin_function_mux_pkg::OFS_DATA[0], 32'h0000_0005);
      busWrite(port_pin_function_mux_pkg::OFS_DIR[2], 32'h0000_001C);
      busWrite(port_pin_function_mux_pkg::OFS_DATA[2], 32'h0000_0014);
      busWrite(port_pin_function_mux_pkg::OFS_DIR[1], 32'h0000_000F);
      busWrite(port_pin_function_mux_pkg::OFS_OPT[1], 32'h0000_0000);
      busWrite(port_pin_function_mux_pkg::OFS_DATA[1], 32'h0000_000A);
      settle();
      for (int i = 0; i < 4; i++) begin
         lineChk(i, {~i[0], 1'b0});
         if (i < 3) lineChk(10 + i, {~i[0], 1'b0});
         chk("odOeN", {31'h0000_0000, i[0]}, {31'h0000_0000, pinDrive[4 + i].oeN});
         if (!i[0]) lineChk(4 + i, 2'b00);
      end
      readChk("dataA", port_pin_function_mux_pkg::OFS_DATA[0], 32'h0000_0005);
      readChk("dataB", port_pin_function_mux_pkg::OFS_DATA[1], 32'h0000_00CA);
      // Timer output routing, then back to a port bit; line 8 stays an input
      busWrite(port_pin_function_mux_pkg::OFS_CTRL, 32'h0000_0001);
      for (int v = 0; v < 2; v++) begin
         timerOut <= v[0];
         boardOeN[8] <= 1'b0;
         boardVal[8] <= ~v[0];
         settle();
         lineChk(9, {v[0], 1'b0});
         chk("timerIn", {31'h0000_0000, ~v[0]}, {31'h0000_0000, timerIn});
      end
      boardOeN[8] <= 1'b1;
      busWrite(port_pin_function_mux_pkg::OFS_CTRL, 32'h0000_0000);
      settle();
      chk("timerOff", 32'h0000_0001, {31'h0000_0000, pinDrive[9].oeN});
      // SPI alternate on the third port
      busWrite(port_pin_function_mux_pkg::OFS_CTRL, 32'h0000_0002);
      for (int v = 0; v < 2; v++) begin
         spiDout <= v[0];
         spiClk <= v[0];
         spiClkOeN <= 1'b0;
         boardOeN[10] <= 1'b0;
         boardVal[10] <= ~v[0];
         settle();
         chk("spiInOeN", 32'h0000_0001, {31'h0000_0000, pinDrive[10].oeN});
         lineChk(11, {v[0], 1'b0});
         lineChk(12, {v[0], 1'b0});
         chk("spiDin", {31'h0000_0000, ~v[0]}, {31'h0000_0000, spiDin});
         chk("spiClkIn", {31'h0000_0000, v[0]}, {31'h0000_0000, spiClkIn});
      end
      spiClkOeN <= 1'b1;
      boardOeN[10] <= 1'b1;
      settle();
      chk("spiClkOeN", 32'h0000_0001, {31'h0000_0000, pinDrive[12].oeN});
      busWrite(port_pin_function_mux_pkg::OFS_CTRL, 32'h0000_0000);
      // NMI: one pulse per fall, none on rise
      nmiPin <= 1'b0;
      countPulse(n);
      chk("nmiFall", 32'h0000_0001, 32'(n));
      readChk("statNmi", port_pin_function_mux_pkg::OFS_IRQ_STAT, 32'h0000_2000);
      nmiPin <= 1'b1;
      countPulse(n);
      chk("nmiRise", 32'h0000_0000, 32'(n));
      busWrite(port_pin_function_mux_pkg::OFS_IRQ_STAT, 32'h0000_2000);
      readChk("statNmiClr", port_pin_function_mux_pkg::OFS_IRQ_STAT, 32'h0000_0000);
      // Reset pin with and without the programming level on the test pin
      for (int v = 1; v >= 0; v--) begin
         testPin <= v[0];
         resetPinN <= 1'b0;
         settle();
         chk("chipResetOn", 32'h0000_0001, {31'h0000_0000, chipReset});
         resetPinN <= 1'b1;
         settle();
         chk("chipResetOff", 32'h0000_0000, {31'h0000_0000, chipReset});
         chk("progMode", {31'h0000_0000, v[0]}, {31'h0000_0000, progMode});
      end
      testPin <= 1'b0;
      test_done();
   end

   initial begin
      #100us;
      errors++;
      test_done();
   end
endmodule : testbench
`default_nettype wire
